// ### crt_pkg.sv
/*
 package of the cascaded reload timer: register offsets, field positions,
 reset values and count-source codes. assumes nothing of its surroundings.
*/
package crt_pkg;
   // ***************
   // register map
   // ***************
   localparam logic [11:0] ADDR_MODE = 12'h000;
   localparam logic [11:0] ADDR_PRESCALER = 12'h004;
   localparam logic [11:0] ADDR_PRIMARY = 12'h008;
   localparam logic [11:0] ADDR_SOURCE = 12'h00c;
   localparam logic [11:0] ADDR_IRQ = 12'h010;
   // ***************
   // mode register fields
   // ***************
   localparam int MODE_LOW_POS = 4;
   localparam int MODE_HIGH_POS = 5;
   localparam int WTS_POS = 6;
   localparam int RUN_POS = 7;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [1:0] MODE_TIMER = 2'h0;
   localparam logic [7:0] PRESCALER_RESET = 8'hff;
   localparam logic [7:0] PRIMARY_RESET = 8'hff;
   // ***************
   // count sources
   // ***************
   localparam logic [1:0] SRC_UNDIVIDED = 2'h0;
   localparam logic [1:0] SRC_HALF = 2'h1;
   localparam logic [1:0] SRC_EIGHTH = 2'h2;
   localparam logic [1:0] SRC_NEIGHBOUR = 2'h3;
   localparam logic [2:0] DIV_EIGHTH_LAST = 3'h7;
   localparam int WRITE_PHASES = 3;
endpackage

// ### crt_source.sv
/*
 count source selector: produces a one-cycle tick from the undivided,
 half or eighth rate clock or the neighbour underflow.
 assumes neighbour underflow is a one-cycle pulse on pclk.
*/
`timescale 1ns/10ps
module crt_source
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [1:0] sel,
   input wire logic neighbour_uf,
   output logic tick
);
   logic [2:0] div_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_reg <= 3'h0;
      else if (ce)
         div_reg <= div_reg + 3'h1;
   end

   always_comb
   begin
      unique case (sel)
         crt_pkg::SRC_UNDIVIDED: tick = ce;
         crt_pkg::SRC_HALF: tick = ce && div_reg[0];
         crt_pkg::SRC_EIGHTH: tick = ce && (div_reg == crt_pkg::DIV_EIGHTH_LAST);
         crt_pkg::SRC_NEIGHBOUR: tick = ce && neighbour_uf;
      endcase
   end
endmodule

// ### crt_stage.sv
/*
 one 8-bit down-counter stage with reload register and the delayed write
 path. assumes step and wr are one-cycle pulses on pclk.
*/
`timescale 1ns/10ps
module crt_stage
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [7:0] reset_value,
   input wire logic tick,
   input wire logic step,
   input wire logic running,
   input wire logic wts,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] count,
   output logic [7:0] reload,
   output logic underflow,
   output logic busy
);
   logic [7:0] reload_reg;
   logic [7:0] count_reg;
   logic [7:0] pend_reg;
   logic [1:0] phase_reg;

   assign count = count_reg;
   assign reload = reload_reg;
   assign busy = phase_reg != 2'h0;
   assign underflow = step && running && !busy && count_reg == 8'h00;

   // delayed write sequencer: latch, transfer, resume
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase_reg <= 2'h0;
      else if (ce)
      begin
         if (wr && running && !wts)
            phase_reg <= 2'h1;
         else if (tick && busy)
            phase_reg <= (phase_reg == 2'(crt_pkg::WRITE_PHASES - 1)) ? 2'h0 : phase_reg + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pend_reg <= 8'h00;
      else if (ce && wr)
         pend_reg <= wdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reload_reg <= 8'h00;
      else if (!ce)
         reload_reg <= reload_reg;
      else if (wr && (!running || wts))
         reload_reg <= wdata;
      else if (tick && phase_reg == 2'h1)
         reload_reg <= pend_reg;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_reg <= 8'h00;
      else if (!ce)
         count_reg <= count_reg;
      else if (wr && !running)
         count_reg <= wdata;
      else if (tick && phase_reg == 2'h2)
         count_reg <= reload_reg;
      else if (underflow)
         count_reg <= reload_reg;
      else if (step && running && !busy)
         count_reg <= count_reg - 8'h01;
   end
endmodule

// ### crt_timer.sv
/*
 cascaded reload timer, timer mode: 8-bit prescaler feeding 8-bit primary
 down-counter, apb slave for mode, count, source and irq registers.
 assumes an apb master on pclk and a neighbour underflow pulse on pclk.
*/
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
module crt_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic neighbour_uf,
   output logic interrupt_request_flag,
   output logic waveform_output_pin,
   output logic waveform_output_oe
);
   // ***************
   // apb decode
   // ***************
   logic wr_en;
   logic hit_mode;
   logic hit_pre;
   logic hit_pri;
   logic hit_src;
   logic hit_irq;
   logic mapped;
   logic [7:0] timer_mode_control_reg;
   logic [1:0] source_reg;
   logic irq_reg;
   logic [31:0] prdata_reg;
   logic run_control_bit;
   logic write_target_select;
   logic timer_mode;
   logic running;
   logic tick;
   logic pre_uf;
   logic pri_uf;
   logic pre_busy;
   logic pri_busy;
   logic [7:0] pre_count;
   logic [7:0] pri_count;
   logic pre_wr;
   logic pri_wr;

   assign hit_mode = paddr == crt_pkg::ADDR_MODE;
   assign hit_pre = paddr == crt_pkg::ADDR_PRESCALER;
   assign hit_pri = paddr == crt_pkg::ADDR_PRIMARY;
   assign hit_src = paddr == crt_pkg::ADDR_SOURCE;
   assign hit_irq = paddr == crt_pkg::ADDR_IRQ;
   assign mapped = hit_mode || hit_pre || hit_pri || hit_src || hit_irq;
   assign wr_en = ce && psel && penable && pwrite && mapped && pstrb[0];
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_reg;

   assign run_control_bit = timer_mode_control_reg[crt_pkg::RUN_POS];
   assign write_target_select = timer_mode_control_reg[crt_pkg::WTS_POS];
   assign timer_mode = {timer_mode_control_reg[crt_pkg::MODE_HIGH_POS],
                        timer_mode_control_reg[crt_pkg::MODE_LOW_POS]} == crt_pkg::MODE_TIMER;
   assign running = run_control_bit && timer_mode;
   assign pre_wr = wr_en && hit_pre;
   assign pri_wr = wr_en && hit_pri;

   // ***************
   // mode and source registers
   // ***************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_mode_control_reg <= crt_pkg::MODE_RESET;
      else if (wr_en && hit_mode)
         timer_mode_control_reg <= {pwdata[7:4], 4'h0};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         source_reg <= crt_pkg::SRC_UNDIVIDED;
      else if (wr_en && hit_src)
         source_reg <= pwdata[1:0];
   end

   // ***************
   // interrupt request flag
   // ***************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_reg <= 1'b0;
      else if (!ce)
         irq_reg <= irq_reg;
      else if (pri_uf)
         irq_reg <= 1'b1;
      else if ((pre_wr || pri_wr) && running && !write_target_select)
         irq_reg <= 1'b1;
      else if (wr_en && hit_irq && !pwdata[0])
         irq_reg <= 1'b0;
   end

   assign interrupt_request_flag = irq_reg;

   // ***************
   // read data
   // ***************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0;
      else if (ce && psel && !penable && !pwrite)
      begin
         if (hit_mode)
            prdata_reg <= {24'h0, timer_mode_control_reg};
         else if (hit_pre)
            prdata_reg <= {24'h0, pre_count};
         else if (hit_pri)
            prdata_reg <= {24'h0, pri_count};
         else if (hit_src)
            prdata_reg <= {30'h0, source_reg};
         else if (hit_irq)
            prdata_reg <= {31'h0, irq_reg};
         else
            prdata_reg <= 32'h0;
      end
   end

   // ***************
   // pins
   // ***************
   assign waveform_output_pin = 1'b0;
   assign waveform_output_oe = 1'b0;

   // ***************
   // counter chain
   // ***************
   crt_source u_source
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .sel(source_reg),
      .neighbour_uf(neighbour_uf),
      .tick(tick)
   );

   crt_stage u_prescaler
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .reset_value(crt_pkg::PRESCALER_RESET),
      .tick(tick),
      .step(tick),
      .running(running),
      .wts(write_target_select),
      .wr(pre_wr),
      .wdata(pwdata[7:0]),
      .count(pre_count),
      .reload(),
      .underflow(pre_uf),
      .busy(pre_busy)
   );

   crt_stage u_primary
   (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .reset_value(crt_pkg::PRIMARY_RESET),
      .tick(tick),
      .step(pre_uf && !pri_busy),
      .running(running),
      .wts(write_target_select),
      .wr(pri_wr),
      .wdata(pwdata[7:0]),
      .count(pri_count),
      .reload(),
      .underflow(pri_uf),
      .busy(pri_busy)
   );
endmodule

// ### crt_timer_props.sv
/*
 checker of the cascaded reload timer ports.
 assumes the apb and pin ports of crt_timer on one clock.
*/
`timescale 1ns/10ps
module crt_timer_props
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic neighbour_uf,
   input wire logic interrupt_request_flag,
   input wire logic waveform_output_pin,
   input wire logic waveform_output_oe
);
   logic [7:0] mode_q;
   logic mapped, wr_hit, run, cnt_wr;
   assign mapped = paddr <= 12'h010 && paddr[1:0] == 2'h0;
   assign wr_hit = psel && penable && pwrite && ce && pstrb[0] && mapped;
   assign run = mode_q[7] && mode_q[5:4] == crt_pkg::MODE_TIMER;
   assign cnt_wr = paddr == crt_pkg::ADDR_PRESCALER || paddr == crt_pkg::ADDR_PRIMARY;
   // shadow of the mode register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mode_q <= crt_pkg::MODE_RESET;
      else if (wr_hit && paddr == crt_pkg::ADDR_MODE)
         mode_q <= {pwdata[7:4], 4'h0};
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_WAVE_IDLE: assert property (!waveform_output_oe && !waveform_output_pin)
      else $error("waveform pin driven");
   AST_READY: assert property (pready)
      else $error("pready low");
   AST_SLVERR: assert property (psel && penable |-> pslverr == !mapped)
      else $error("pslverr wrong");
   AST_WRITE_IRQ: assert property (wr_hit && run && !mode_q[6] && cnt_wr |=>
      interrupt_request_flag) else $error("running write did not set flag");
   AST_IRQ_HOLD: assert property (interrupt_request_flag && !(wr_hit &&
      paddr == crt_pkg::ADDR_IRQ && !pwdata[0]) |=> interrupt_request_flag)
      else $error("flag dropped without clear");
   AST_IRQ_CAUSE: assert property ($rose(interrupt_request_flag) |->
      $past(run) || $past(run, 2)) else $error("flag set while halted");
   AST_MODE_READ: assert property (psel && !penable && !pwrite && ce &&
      paddr == crt_pkg::ADDR_MODE |=> prdata == {24'h0, $past(mode_q)})
      else $error("mode read wrong");
   AST_UPPER_ZERO: assert property (psel && penable && !pwrite |->
      prdata[31:8] == 24'h0) else $error("upper read bits set");
   AST_FREEZE: assert property (!ce |=> $stable(interrupt_request_flag))
      else $error("state moved with ce low");
endmodule
bind crt_timer crt_timer_props u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .neighbour_uf(neighbour_uf), .interrupt_request_flag(interrupt_request_flag),
   .waveform_output_pin(waveform_output_pin), .waveform_output_oe(waveform_output_oe));

// ### test_cascaded_reload_timer_mode.sv
/*
 self-checking bench of the cascaded reload timer in timer mode.
 assumes crt_timer, crt_pkg and the bound checker.
*/
`timescale 1ns/10ps
module test_cascaded_reload_timer_mode;
   logic pclk, presetn, ce, psel, penable, pwrite, neighbour_uf, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [3:0] pstrb;
   logic [1:0] nbc;
   logic [31:0] expq[$];
   int errors, checked, cyc;
   crt_timer DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .neighbour_uf(neighbour_uf),
      .interrupt_request_flag(irq), .waveform_output_pin(), .waveform_output_oe());
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ***************
   // helpers
   // ***************
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask
   task wait_irq;
      for (int k = 0; k < 3000 && irq !== 1'b1; k++)
         @(posedge pclk);
      if (irq !== 1'b1)
         errors++;
   endtask
   task period(input int k, input logic [1:0] src);
      int n, m, t0;
      n = int'(rnd() & 32'h3) + 1;
      m = int'(rnd() & 32'h3) + 2;
      wr(crt_pkg::ADDR_MODE, 32'h0);
      wr(crt_pkg::ADDR_SOURCE, {30'h0, src});
      wr(crt_pkg::ADDR_PRESCALER, n);
      wr(crt_pkg::ADDR_PRIMARY, m);
      wr(crt_pkg::ADDR_IRQ, 32'h0);
      wr(crt_pkg::ADDR_MODE, 32'h80);
      wait_irq();
      t0 = cyc;
      wr(crt_pkg::ADDR_IRQ, 32'h0);
      wait_irq();
      check(32'(cyc - t0), 32'(k * (n + 1) * (m + 1)));
   endtask
   // ***************
   // monitor, neighbour pulses, timeout
   // ***************
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      nbc <= (nbc == 2'h2) ? 2'h0 : nbc + 2'h1;
      neighbour_uf <= nbc == 2'h2;
      if (psel && penable && !pwrite && pready)
         check(prdata, expq.pop_front());
      if (cyc == 30000)
      begin
         errors++;
         give_verdict();
      end
   end
   // ***************
   // main sequence
   // ***************
   initial
   begin
      {presetn, psel, penable, pwrite, neighbour_uf} = 5'h0;
      {paddr, pwdata, nbc, errors, checked} = 0;
      ce = 1'b1;
      pstrb = 4'hf;
      seed = 32'h90fb;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(crt_pkg::ADDR_MODE, 32'h0);
      rd(crt_pkg::ADDR_PRIMARY, 32'h0);
      wr(crt_pkg::ADDR_MODE, 32'h4f);
      rd(crt_pkg::ADDR_MODE, 32'h40);
      wr(crt_pkg::ADDR_PRESCALER, 32'h5a);
      rd(crt_pkg::ADDR_PRESCALER, 32'h5a);
      ce <= 1'b0;
      wr(crt_pkg::ADDR_PRESCALER, 32'h11);
      ce <= 1'b1;
      rd(crt_pkg::ADDR_PRESCALER, 32'h5a);
      rd(12'h014, 32'h0);
      period(1, crt_pkg::SRC_UNDIVIDED);
      period(2, crt_pkg::SRC_HALF);
      period(8, crt_pkg::SRC_EIGHTH);
      period(3, crt_pkg::SRC_NEIGHBOUR);
      wr(crt_pkg::ADDR_MODE, 32'h0);
      wr(crt_pkg::ADDR_SOURCE, {30'h0, crt_pkg::SRC_UNDIVIDED});
      wr(crt_pkg::ADDR_PRESCALER, 32'hff);
      wr(crt_pkg::ADDR_PRIMARY, 32'hff);
      wr(crt_pkg::ADDR_IRQ, 32'h0);
      wr(crt_pkg::ADDR_MODE, 32'hc0);
      wr(crt_pkg::ADDR_PRIMARY, 32'h03);
      rd(crt_pkg::ADDR_IRQ, 32'h0);
      rd(crt_pkg::ADDR_PRIMARY, 32'hff);
      wr(crt_pkg::ADDR_MODE, 32'h0);
      wr(crt_pkg::ADDR_PRESCALER, 32'hff);
      wr(crt_pkg::ADDR_MODE, 32'h80);
      wr(crt_pkg::ADDR_PRESCALER, 32'h10);
      rd(crt_pkg::ADDR_PRESCALER, 32'hfc);
      rd(crt_pkg::ADDR_PRESCALER, 32'h0e);
      rd(crt_pkg::ADDR_IRQ, 32'h1);
      give_verdict();
   end
endmodule
